// ==== logic/bbp_pkg.sv ====
// Shared constants of the backplane block pager: image sizes, block layouts, limits.
// Assumes 16-bit image words and a single ref_clk domain for everything but pins.
package bbp_pkg;
  // Image and database sizes
  localparam int         IMG_IN_WORDS  = 250;          // Words presented to the host
  localparam int         IMG_OUT_WORDS = 248;          // Words accepted from the host
  localparam int         DB_WORDS      = 7000;         // Database indices 0..6999
  localparam int         USER_WORDS    = 5000;         // Paged user area 0..4999
  localparam int         DB_AW         = 13;
  localparam logic [12:0] BLK_WORDS    = 13'h00C8;     // 200 data words per block
  localparam logic [15:0] MAX_BLKS     = 16'h0019;     // 25 blocks cover the user area

  // Read block (input image) offsets
  localparam logic [7:0] RB_WBID   = 8'h01;            // Requested write block
  localparam logic [7:0] RB_DATA0  = 8'h02;            // First user word
  localparam logic [7:0] RB_DATAN  = 8'hC9;            // 201, last user word
  localparam logic [7:0] RB_SCAN   = 8'hCA;            // 202, scan counter
  localparam logic [7:0] RB_PCODE  = 8'hCB;            // 203..204
  localparam logic [7:0] RB_PVER   = 8'hCD;            // 205..206
  localparam logic [7:0] RB_OPSYS  = 8'hCF;            // 207..208
  localparam logic [7:0] RB_RUNNO  = 8'hD1;            // 209..210
  localparam logic [7:0] RB_XFER   = 8'hE1;            // 225..230 transfer status
  localparam logic [7:0] RB_P1CUR  = 8'hE7;            // 231
  localparam logic [7:0] RB_P1LAST = 8'hE8;            // 232
  localparam logic [7:0] RB_P2CUR  = 8'hE9;            // 233
  localparam logic [7:0] RB_P2LAST = 8'hEA;            // 234
  localparam logic [7:0] RB_RBID   = 8'hF9;            // 249, read block ID
  localparam logic [7:0] RB_CFGERR = 8'h02;            // Config request: error word
  localparam logic [7:0] RB_LAST   = 8'hF9;            // Last input image word

  // Write block (output image) offsets
  localparam logic [7:0] WB_ID     = 8'h00;
  localparam logic [7:0] WB_DATAN  = 8'hC8;            // 200, last data word
  localparam logic [7:0] WB_LAST   = 8'hF7;            // 247, last accepted word
  localparam logic [7:0] CW_NRD    = 8'h01;            // Config: read block count
  localparam logic [7:0] CW_NWR    = 8'h02;            // Config: write block count
  localparam logic [7:0] CW_FLAGS  = 8'h03;            // Config: bit0 shut ports off-run

  // Special block codes
  localparam logic [15:0] CFG_BLK_ID = 16'h2328;       // 9000, general configuration
  localparam logic [15:0] CFG_RBID   = 16'hFFFE;       // -2, config request read ID

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef logic [15:0] bbp_word_t;
  typedef enum logic [1:0] {
    ST_CFG = 2'b01,
    ST_RUN = 2'b10
  } bbp_state_t;
endpackage

// ==== logic/bbp_db_if.sv ====
// Link between the pager and its word database: one write and one read port.
// Assumes both ends run on the same clock; read data lags the address by one edge.
interface bbp_db_if;
  logic                   we;
  logic [12:0]            waddr;
  bbp_pkg::bbp_word_t     wdata;
  logic [12:0]            raddr;
  bbp_pkg::bbp_word_t     rdata;

  modport pager (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== logic/bbp_db.sv ====
// Word database of the pager, held in flip-flops and addressed by index.
// Assumes the pager keeps write addresses inside the table; read is registered.
module bbp_db (
  input wire logic ref_clk,
  input wire logic rstn,
  bbp_db_if.store  port
);
  import bbp_pkg::*;

  bbp_word_t mem [DB_WORDS];

  // Data words carry no reset; only the read register does
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // Registered read keeps the pager's output path one flop deep
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port.rdata <= RST_WORD;
    end else begin
      port.rdata <= mem[port.raddr];
    end
  end

  a_db_range: assert property (@(posedge ref_clk) disable iff (!rstn)
    port.we |-> (port.waddr < 13'(DB_WORDS)))
    else $error("database write outside 0..6999");
endmodule

// ==== logic/bbp_pager.sv ====
// Backplane block pager: builds read blocks for the host, takes in write blocks.
// Assumes image word strobes come from logic on ref_clk; mode and debug are pins.
module bbp_pager #(
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] PRODUCT_VER  = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] OPSYS_VER    = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] RUN_NUMBER   = 32'h0000_0001  // Arbitrary value
) (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               host_program_mode,
  input  wire logic               debug_hold,
  input  wire logic               fb_cmd_req,
  input  wire bbp_pkg::bbp_word_t port1_err,
  input  wire bbp_pkg::bbp_word_t port2_err,
  input  wire logic               out_valid,
  input  wire logic [7:0]         out_idx,
  input  wire bbp_pkg::bbp_word_t out_word,
  input  wire logic               out_last,
  input  wire logic               in_rd_en,
  input  wire logic [7:0]         in_rd_idx,
  output bbp_pkg::bbp_word_t      in_rd_data,
  output logic                    in_rd_valid,
  output logic                    fieldbus_enable,
  output logic                    cfg_done
);
  import bbp_pkg::*;

  bbp_db_if db ();

  bbp_db u_db (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .port    (db.store)
  );

  // Block index to first database word
  function automatic logic [12:0] blk_base(input logic [4:0] n);
    blk_base = 13'(n) * BLK_WORDS;
  endfunction

  // Next block in a cyclic sequence of n blocks
  function automatic logic [4:0] inc_wrap(input logic [4:0] v, input logic [4:0] n);
    inc_wrap = ((v + 5'h01) >= n) ? 5'h00 : (v + 5'h01);
  endfunction

  bbp_state_t st;
  logic [4:0] n_rd;
  logic [4:0] n_wr;
  logic       shut_off_run;
  logic [4:0] rd_blk;
  logic [4:0] wr_req;
  bbp_word_t  scan;
  bbp_word_t  cnt_rd;
  bbp_word_t  cnt_wr;
  bbp_word_t  cnt_bad;
  bbp_word_t  cnt_brk;
  bbp_word_t  cfg_err;
  bbp_word_t  wid;
  logic       wid_ok;
  logic       wid_cfg;
  bbp_word_t  nrd_stage;
  bbp_word_t  nwr_stage;
  bbp_word_t  flg_stage;
  logic       brk_pend;
  logic       pm_s1;
  logic       pm_s2;
  logic       dh_s1;
  logic       dh_s2;
  logic       dh_d;
  bbp_word_t  p1_last;
  bbp_word_t  p2_last;
  logic       rd_v1;
  logic       rd_db1;
  bbp_word_t  rd_w1;
  bbp_word_t  next_word;
  logic       upd;
  logic       brk_now;
  logic       id_valid;
  logic       cfg_bad;

  assign upd      = out_valid && out_last;
  assign brk_now  = fb_cmd_req || (dh_s2 && !dh_d);
  assign cfg_bad  = (nrd_stage == RST_WORD) || (nrd_stage > MAX_BLKS) || (nwr_stage > MAX_BLKS);
  // Config block is always known; user IDs only once block counts exist
  assign id_valid = (out_word == CFG_BLK_ID) ||
                    ((st == ST_RUN) && (out_word < 16'(n_wr)));

  // Pins from outside the clock domain pass two flops first
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pm_s1 <= 1'b0;
      pm_s2 <= 1'b0;
      dh_s1 <= 1'b0;
      dh_s2 <= 1'b0;
      dh_d  <= 1'b0;
    end else begin
      pm_s1 <= host_program_mode;
      pm_s2 <= pm_s1;
      dh_s1 <= debug_hold;
      dh_s2 <= dh_s1;
      dh_d  <= dh_s2;
    end
  end

  // Header word of each incoming write block decides its fate
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wid     <= RST_WORD;
      wid_ok  <= 1'b0;
      wid_cfg <= 1'b0;
    end else if (out_valid && out_idx == WB_ID) begin
      wid     <= out_word;
      wid_ok  <= id_valid;
      wid_cfg <= (out_word == CFG_BLK_ID);
    end
  end

  // Data words go straight into the database; nothing past offset 200 is stored
  assign db.we    = out_valid && wid_ok && !wid_cfg &&
                    (out_idx != WB_ID) && (out_idx <= WB_DATAN);
  assign db.waddr = blk_base(wid[4:0]) + 13'(out_idx) - 13'h0001;
  assign db.wdata = out_word;
  assign db.raddr = blk_base(rd_blk) + 13'(in_rd_idx) - 13'(RB_DATA0);

  // Configuration words are staged until the whole block has arrived
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nrd_stage <= RST_WORD;
      nwr_stage <= RST_WORD;
      flg_stage <= RST_WORD;
    end else if (out_valid && wid_ok && wid_cfg) begin
      if (out_idx == CW_NRD) nrd_stage <= out_word;
      if (out_idx == CW_NWR) nwr_stage <= out_word;
      if (out_idx == CW_FLAGS) flg_stage <= out_word;
    end
  end

  // Mode: wait for a clean configuration block after restart, then page
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st           <= ST_CFG;
      n_rd         <= 5'h00;
      n_wr         <= 5'h00;
      shut_off_run <= 1'b0;
      cfg_err      <= RST_WORD;
    end else if (upd && wid_ok && wid_cfg) begin
      cfg_err <= {14'h0000, (nwr_stage > MAX_BLKS),
                  (nrd_stage == RST_WORD) || (nrd_stage > MAX_BLKS)};
      case (st)
        ST_CFG, ST_RUN: begin
          if (!cfg_bad) begin
            st           <= ST_RUN;
            n_rd         <= nrd_stage[4:0];
            n_wr         <= nwr_stage[4:0];
            shut_off_run <= flg_stage[0];
          end
        end
        default: st <= ST_CFG;
      endcase
    end
  end

  // Paging sequence and its interruptions
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_blk   <= 5'h00;
      wr_req   <= 5'h00;
      brk_pend <= 1'b0;
    end else if (upd && st == ST_RUN && !wid_cfg) begin
      // A break arriving in this very cycle stays pending for the next update
      brk_pend <= brk_now;
      if (brk_pend) begin
        rd_blk <= rd_blk;
      end else if (wid_ok && wid[4:0] != wr_req) begin
        rd_blk <= inc_wrap(rd_blk, n_rd);
        wr_req <= inc_wrap(wid[4:0], n_wr);
      end else begin
        rd_blk <= inc_wrap(rd_blk, n_rd);
        wr_req <= inc_wrap(wr_req, n_wr);
      end
    end else if (upd && wid_ok && wid_cfg && !cfg_bad) begin
      rd_blk   <= 5'h00;
      wr_req   <= 5'h00;
      brk_pend <= brk_now;
    end else begin
      brk_pend <= brk_pend || brk_now;
    end
  end

  // Status counters, refreshed on every update
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scan    <= RST_WORD;
      cnt_rd  <= RST_WORD;
      cnt_wr  <= RST_WORD;
      cnt_bad <= RST_WORD;
      cnt_brk <= RST_WORD;
    end else if (upd) begin
      scan    <= scan + 16'h0001;
      cnt_rd  <= cnt_rd + 16'h0001;
      cnt_wr  <= wid_ok ? cnt_wr + 16'h0001 : cnt_wr;
      cnt_bad <= wid_ok ? cnt_bad : cnt_bad + 16'h0001;
      cnt_brk <= (brk_pend && st == ST_RUN) ? cnt_brk + 16'h0001 : cnt_brk;
    end
  end

  // Last nonzero error code per port
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      p1_last <= RST_WORD;
      p2_last <= RST_WORD;
    end else begin
      if (port1_err != RST_WORD) p1_last <= port1_err;
      if (port2_err != RST_WORD) p2_last <= port2_err;
    end
  end

  // Fieldbus ports follow host run mode only if configured to
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fieldbus_enable <= 1'b0;
      cfg_done        <= 1'b0;
    end else begin
      fieldbus_enable <= (st == ST_RUN) && !(pm_s2 && shut_off_run);
      cfg_done        <= (st == ST_RUN);
    end
  end

  // Non-database words of the read block; offsets with no assignment read as zero here
  always_comb begin
    next_word = RST_WORD;
    if (st == ST_CFG) begin
      if (in_rd_idx == RB_WBID) next_word = CFG_BLK_ID;
      else if (in_rd_idx == RB_CFGERR) next_word = cfg_err;
      else if (in_rd_idx == RB_RBID) next_word = CFG_RBID;
    end else begin
      case (in_rd_idx)
        RB_WBID:          next_word = 16'(wr_req);
        RB_SCAN:          next_word = scan;
        RB_PCODE:         next_word = PRODUCT_CODE[15:0];
        RB_PCODE + 8'h01: next_word = PRODUCT_CODE[31:16];
        RB_PVER:          next_word = PRODUCT_VER[15:0];
        RB_PVER + 8'h01:  next_word = PRODUCT_VER[31:16];
        RB_OPSYS:         next_word = OPSYS_VER[15:0];
        RB_OPSYS + 8'h01: next_word = OPSYS_VER[31:16];
        RB_RUNNO:         next_word = RUN_NUMBER[15:0];
        RB_RUNNO + 8'h01: next_word = RUN_NUMBER[31:16];
        RB_XFER:          next_word = cnt_rd;
        RB_XFER + 8'h01:  next_word = cnt_wr;
        RB_XFER + 8'h02:  next_word = cnt_bad;
        RB_XFER + 8'h03:  next_word = cnt_brk;
        RB_XFER + 8'h04:  next_word = cfg_err;
        RB_XFER + 8'h05:  next_word = wid;
        RB_P1CUR:         next_word = port1_err;
        RB_P1LAST:        next_word = p1_last;
        RB_P2CUR:         next_word = port2_err;
        RB_P2LAST:        next_word = p2_last;
        RB_RBID:          next_word = 16'(rd_blk);
        default:          next_word = RST_WORD;
      endcase
    end
  end

  // Two-stage read: index decode plus database fetch, then output flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_v1       <= 1'b0;
      rd_db1      <= 1'b0;
      rd_w1       <= RST_WORD;
      in_rd_valid <= 1'b0;
      in_rd_data  <= RST_WORD;
    end else begin
      rd_v1       <= in_rd_en;
      rd_db1      <= (st == ST_RUN) && (in_rd_idx >= RB_DATA0) && (in_rd_idx <= RB_DATAN);
      rd_w1       <= (in_rd_idx <= RB_LAST) ? next_word : RST_WORD;
      in_rd_valid <= rd_v1;
      in_rd_data  <= rd_db1 ? db.rdata : rd_w1;
    end
  end

  a_rd_latency: assert property (@(posedge ref_clk) disable iff (!rstn)
    in_rd_en |-> ##2 in_rd_valid)
    else $error("input image word not answered in two cycles");

  a_user_area: assert property (@(posedge ref_clk) disable iff (!rstn)
    db.we |-> (db.waddr < 13'(USER_WORDS)))
    else $error("paging wrote outside the user area");

  a_wr_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    db.we |-> (db.waddr == 13'(wid[4:0]) * BLK_WORDS + 13'(out_idx) - 13'h0001))
    else $error("write block word stored at wrong index");

  a_bad_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
    (out_valid && out_idx == WB_ID && !id_valid) |=>
    (!wid_ok && !db.we))
    else $error("unknown write block reached the database");

  a_cfg_poll: assert property (@(posedge ref_clk) disable iff (!rstn)
    (in_rd_en && in_rd_idx == RB_WBID && st == ST_CFG) |-> ##2 (in_rd_data == CFG_BLK_ID))
    else $error("config request missing from read block");

  a_rbid_word: assert property (@(posedge ref_clk) disable iff (!rstn)
    (in_rd_en && in_rd_idx == RB_RBID && st == ST_RUN) |->
    ##2 (in_rd_data == 16'($past(rd_blk, 2))))
    else $error("read block ID word wrong");

  a_seq_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    (upd && st == ST_RUN && !wid_cfg && !brk_pend && wid_ok && wid[4:0] == wr_req) |=>
    (rd_blk == (($past(rd_blk) + 5'h01 >= n_rd) ? 5'h00 : $past(rd_blk) + 5'h01)))
    else $error("read block sequence did not advance");

  a_brk_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    (upd && st == ST_RUN && !wid_cfg && brk_pend) |=> $stable(rd_blk) && $stable(wr_req))
    else $error("sequence moved during a break");

  a_scan_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    upd |=> (scan == $past(scan) + 16'h0001))
    else $error("scan counter not refreshed");

  a_port_shut: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st == ST_RUN && pm_s2 && shut_off_run) |=> !fieldbus_enable)
    else $error("ports left on with host out of run");

  a_port_resume: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st == ST_RUN && !pm_s2) |=> fieldbus_enable)
    else $error("ports not resumed in run mode");
endmodule

// ==== dv/bbp_host_model.sv ====
// Host controller model: fills the output image and scans the input image.
// Assumes the pager samples on rising ref_clk; this model drives on falling edges.
module bbp_host_model (
  input  wire logic               ref_clk,
  output logic                    out_valid,
  output logic [7:0]              out_idx,
  output bbp_pkg::bbp_word_t      out_word,
  output logic                    out_last,
  output logic                    in_rd_en,
  output logic [7:0]              in_rd_idx,
  input  wire bbp_pkg::bbp_word_t in_rd_data,
  input  wire logic               in_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;

  // Idle image lines at time zero
  initial begin
    out_valid = 1'b0;
    out_idx   = 8'h00;
    out_word  = 16'h0000;
    out_last  = 1'b0;
    in_rd_en  = 1'b0;
    in_rd_idx = 8'h00;
  end

  // One update: block ID at word 0, then words 1..n, last word flagged
  task automatic send(input bbp_word_t id, input bbp_word_t base, input int n,
                      input bbp_word_t c1, input bbp_word_t c2, input bbp_word_t c3);
    bbp_word_t w;
    for (int k = 0; k <= n; k++) begin
      w = base + 16'(k);
      if (k == 0) w = id;
      if (id == CFG_BLK_ID && k == 1) w = c1;
      if (id == CFG_BLK_ID && k == 2) w = c2;
      if (id == CFG_BLK_ID && k == 3) w = c3;
      @(negedge ref_clk);
      out_valid = 1'b1;
      out_idx   = 8'(k);
      out_word  = w;
      out_last  = (k == n);
    end
    @(negedge ref_clk);
    out_valid = 1'b0;
    out_last  = 1'b0;
    out_word  = ~w; // Released bus must not echo the last word
  endtask

  // Read one input image word; answer expected two edges after the request
  task automatic rd(input logic [7:0] idx, output bbp_word_t d);
    @(negedge ref_clk);
    in_rd_en  = 1'b1;
    in_rd_idx = idx;
    @(negedge ref_clk);
    in_rd_en  = 1'b0;
    in_rd_idx = ~idx;
    // Valid stands for one cycle only, between the second and third edge
    @(negedge ref_clk);
    d = (in_rd_valid === 1'b1) ? in_rd_data : 16'hxxxx;
  endtask
endmodule

// ==== dv/backplane_block_pager_bench.sv ====
// Bench of the block pager: host model on both images, pins driven here.
// Assumes a 200 MHz ref_clk; every input changes on the falling edge.
module backplane_block_pager_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;

  localparam logic [31:0] PCODE = 32'h1234_5678; // Arbitrary value
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       host_program_mode = 1'b0;
  logic       debug_hold = 1'b0;
  logic       fb_cmd_req = 1'b0;
  bbp_word_t  port1_err = 16'h0000;
  bbp_word_t  port2_err = 16'h0000;
  logic       out_valid, out_last, in_rd_en, in_rd_valid, fieldbus_enable, cfg_done;
  logic [7:0] out_idx, in_rd_idx;
  bbp_word_t  out_word, in_rd_data, s;
  int         fail_count = 0;
  int         compares = 0;

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

  // 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  bbp_pager #(.PRODUCT_CODE(PCODE)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .host_program_mode(host_program_mode),
    .debug_hold(debug_hold), .fb_cmd_req(fb_cmd_req), .port1_err(port1_err),
    .port2_err(port2_err), .out_valid(out_valid), .out_idx(out_idx),
    .out_word(out_word), .out_last(out_last), .in_rd_en(in_rd_en),
    .in_rd_idx(in_rd_idx), .in_rd_data(in_rd_data), .in_rd_valid(in_rd_valid),
    .fieldbus_enable(fieldbus_enable), .cfg_done(cfg_done));

  bbp_host_model host (
    .ref_clk(ref_clk), .out_valid(out_valid), .out_idx(out_idx),
    .out_word(out_word), .out_last(out_last), .in_rd_en(in_rd_en),
    .in_rd_idx(in_rd_idx), .in_rd_data(in_rd_data), .in_rd_valid(in_rd_valid));

  task automatic close_out();
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] i, input bbp_word_t e);
    bbp_word_t d;
    host.rd(i, d);
    `CHK(nm, e, d)
  endtask

  // Requested write block and read block ID of the current read block
  task automatic chk_seq(input bbp_word_t wr, input bbp_word_t rb);
    chk_rd("wr_req", RB_WBID, wr);
    chk_rd("rd_blk", RB_RBID, rb);
  endtask

  task automatic wait_fbe(input logic v);
    for (int i = 0; i < 12; i++)
      if (fieldbus_enable !== v) @(negedge ref_clk);
  endtask

  task automatic t_reset();
    `CHK("cfg_done", 1'b0, cfg_done)
    `CHK("fb_en", 1'b0, fieldbus_enable)
    chk_rd("cfg_req", RB_WBID, CFG_BLK_ID);
    chk_rd("cfg_rbid", RB_RBID, CFG_RBID);
    chk_rd("cfg_spare", 8'h64, 16'h0000);
    chk_rd("beyond", 8'hFA, 16'h0000);
  endtask

  // Zero read blocks and 26 write blocks are refused; a data block before setup is dropped
  task automatic t_badcfg();
    host.send(CFG_BLK_ID, 16'h0000, 4, 16'h0000, 16'h001A, 16'h0001);
    repeat (2) @(negedge ref_clk);
    `CHK("cfg_done", 1'b0, cfg_done)
    chk_rd("cfg_err", RB_CFGERR, 16'h0003);
    host.send(16'h0005, 16'h5000, 4, 16'h0000, 16'h0000, 16'h0000);
    chk_rd("cfg_req", RB_WBID, CFG_BLK_ID);
  endtask

  // Flags word must not be the final word: staging lands one edge after it
  task automatic t_config(input bbp_word_t flags);
    host.send(CFG_BLK_ID, 16'h0000, 4, 16'h0003, 16'h0002, flags);
    repeat (2) @(negedge ref_clk);
    `CHK("cfg_done", 1'b1, cfg_done)
    `CHK("fb_en", 1'b1, fieldbus_enable)
    chk_seq(16'h0000, 16'h0000);
  endtask

  // Three read blocks, two write blocks: data lands at ID*200
  task automatic t_paging();
    host.rd(RB_SCAN, s);
    host.send(16'h0000, 16'h1000, 200, 16'h0000, 16'h0000, 16'h0000);
    chk_rd("scan", RB_SCAN, s + 16'h0001);
    chk_seq(16'h0001, 16'h0001);
    host.send(16'h0001, 16'h2000, 247, 16'h0000, 16'h0000, 16'h0000);
    chk_seq(16'h0000, 16'h0002);
    host.send(16'h0000, 16'h3000, 200, 16'h0000, 16'h0000, 16'h0000);
    chk_seq(16'h0001, 16'h0000);
    chk_rd("rsvd", 8'h00, 16'h0000);
    chk_rd("db0", RB_DATA0, 16'h3001);
    chk_rd("db199", RB_DATAN, 16'h30C8);
    host.send(16'h0001, 16'h2000, 2, 16'h0000, 16'h0000, 16'h0000);
    chk_rd("db200", RB_DATA0, 16'h2001);
    chk_rd("db399", RB_DATAN, 16'h20C8);
    chk_rd("pc_lo", RB_PCODE, PCODE[15:0]);
    chk_rd("pc_hi", RB_PCODE + 8'h01, PCODE[31:16]);
  endtask

  task automatic t_status();
    port1_err = 16'h0055;
    port2_err = 16'h00AA;
    chk_rd("p1cur", RB_P1CUR, 16'h0055);
    chk_rd("p2last", RB_P2LAST, 16'h00AA);
    port1_err = 16'h0000;
    chk_rd("p1cur", RB_P1CUR, 16'h0000);
    chk_rd("p1last", RB_P1LAST, 16'h0055);
  endtask

  // Breaks hold the sequence; a host ID change redirects it
  task automatic t_break();
    @(negedge ref_clk);
    fb_cmd_req = 1'b1;
    @(negedge ref_clk);
    fb_cmd_req = 1'b0;
    host.send(16'h0000, 16'h6000, 1, 16'h0000, 16'h0000, 16'h0000);
    chk_seq(16'h0000, 16'h0001);
    debug_hold = 1'b1;
    repeat (4) @(negedge ref_clk);
    debug_hold = 1'b0;
    host.send(16'h0000, 16'h6000, 1, 16'h0000, 16'h0000, 16'h0000);
    chk_seq(16'h0000, 16'h0001);
    host.send(16'h0001, 16'h6000, 1, 16'h0000, 16'h0000, 16'h0000);
    chk_seq(16'h0000, 16'h0002);
    host.rd(RB_XFER + 8'h02, s);
    host.send(16'h0007, 16'h7000, 1, 16'h0000, 16'h0000, 16'h0000);
    chk_rd("discards", RB_XFER + 8'h02, s + 16'h0001);
    chk_seq(16'h0001, 16'h0000);
  endtask

  task automatic t_mode();
    host_program_mode = 1'b1;
    wait_fbe(1'b0);
    `CHK("fb_off", 1'b0, fieldbus_enable)
    host_program_mode = 1'b0;
    wait_fbe(1'b1);
    `CHK("fb_on", 1'b1, fieldbus_enable)
    t_config(16'h0000);
    host_program_mode = 1'b1;
    repeat (8) @(negedge ref_clk);
    `CHK("fb_kept", 1'b1, fieldbus_enable)
    host_program_mode = 1'b0;
  endtask

  task automatic t_rst2();
    rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("cfg_rst", 1'b0, cfg_done)
    `CHK("fb_rst", 1'b0, fieldbus_enable)
    rstn = 1'b1;
    chk_rd("cfg_req", RB_WBID, CFG_BLK_ID);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_badcfg();
    t_config(16'h0001);
    t_paging();
    t_status();
    t_break();
    t_mode();
    t_rst2();
    close_out();
  end

  // Watchdog, far beyond the fewer than one thousand cycles the tests need
  initial begin
    #250_000;
    fail_count++;
    close_out();
  end
endmodule
